/* File: design/umh_pkg.sv */
// Shared constants of the modem handshake block
package umh_pkg;

    localparam int          NUM_PORTS   = 2;
    localparam int          ADDR_W      = 8;
    localparam int          DATA_W      = 32;
    localparam int          INT_W       = NUM_PORTS;

    // Register byte offsets, port 1 at the base, port 2 one stride above
    localparam logic [7:0]  OFF_MSR        = 8'h00;
    localparam logic [7:0]  OFF_MCR        = 8'h04;
    localparam logic [7:0]  OFF_IER        = 8'h08;
    localparam logic [7:0]  PORT_STRIDE    = 8'h0C;
    localparam logic [7:0]  OFF_INT_STATUS = 8'h18;
    localparam logic [7:0]  OFF_INT_CLEAR  = 8'h1C;
    localparam logic [7:0]  OFF_INT_ENABLE = 8'h20;

    // Field positions
    localparam int          MSR_DCTS    = 0;
    localparam int          MSR_DDSR    = 1;
    localparam int          MSR_CTS     = 4;
    localparam int          MSR_DSR     = 5;
    localparam int          MCR_DTR     = 0;
    localparam int          MCR_RTS     = 1;
    localparam int          MCR_LOOP    = 4;
    localparam int          IER_MSI     = 3;

    // Reset values
    localparam logic        BIT_RST      = 1'b0;
    localparam logic        PIN_IDLE     = 1'b1;
    localparam logic [1:0]  SYNC_RST     = 2'h3;
    localparam logic [INT_W-1:0] INT_RST = 2'h0;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        UMH_SEL_NONE = 2'b00,
        UMH_SEL_PORT = 2'b01,
        UMH_SEL_INT  = 2'b10
    } umh_sel_t;

endpackage

/* File: design/umh_pin_if.sv */
// Synchronised modem input levels and events of one port
`timescale 1ns/1ps
interface umh_pin_if;
    logic dsrLevelN;    // Synchronised data set ready, active low
    logic ctsLevelN;    // Synchronised clear to send, active low
    logic dsrRise;      // Pin went low to high
    logic ctsRise;      // Pin went low to high
    logic dsrChange;    // Pin changed either way
    logic ctsChange;    // Pin changed either way

    modport src (
        output dsrLevelN,
        output ctsLevelN,
        output dsrRise,
        output ctsRise,
        output dsrChange,
        output ctsChange
    );
    modport dst (
        input dsrLevelN,
        input ctsLevelN,
        input dsrRise,
        input ctsRise,
        input dsrChange,
        input ctsChange
    );
endinterface

/* File: design/umh_pin_sync.sv */
// Two-stage synchroniser and edge finder for one port's modem inputs
`timescale 1ns/1ps
module umh_pin_sync
    import umh_pkg::*;
(
    input  wire logic  core_clk,   // Core clock
    input  wire logic  reset,      // Synchronous reset, active high
    input  wire logic  dsrN,       // Data set ready pin, active low
    input  wire logic  ctsN,       // Clear to send pin, active low
    umh_pin_if.src     pins        // Synchronised levels and events
);
    import umh_pkg::*;

    logic [1:0] dsrSync_q;
    logic [1:0] ctsSync_q;
    logic       dsrPrev_q;
    logic       ctsPrev_q;

    // First stage feeds only the second stage
    always_ff @(posedge core_clk) begin
        if (reset) begin
            dsrSync_q <= SYNC_RST;
            ctsSync_q <= SYNC_RST;
            dsrPrev_q <= PIN_IDLE;
            ctsPrev_q <= PIN_IDLE;
        end else begin
            dsrSync_q <= {dsrSync_q[0], dsrN};
            ctsSync_q <= {ctsSync_q[0], ctsN};
            dsrPrev_q <= dsrSync_q[1];
            ctsPrev_q <= ctsSync_q[1];
        end
    end

    assign pins.dsrLevelN = dsrSync_q[1];
    assign pins.ctsLevelN = ctsSync_q[1];
    assign pins.dsrRise   = dsrSync_q[1] & ~dsrPrev_q;
    assign pins.ctsRise   = ctsSync_q[1] & ~ctsPrev_q;
    assign pins.dsrChange = dsrSync_q[1] ^ dsrPrev_q;
    assign pins.ctsChange = ctsSync_q[1] ^ ctsPrev_q;

endmodule

/* File: design/umh_handshake.sv */
// Modem handshake registers and pins of two serial ports, APB slave
`timescale 1ns/1ps
module umh_handshake
    import umh_pkg::*;
(
    input  wire logic                 core_clk,                // 20 MHz core clock
    input  wire logic                 reset,                   // Sync reset, active high
    input  wire logic                 psel,                    // APB select
    input  wire logic                 penable,                 // APB enable
    input  wire logic                 pwrite,                  // APB direction
    input  wire logic [ADDR_W-1:0]    paddr,                   // APB byte address
    input  wire logic [DATA_W-1:0]    pwdata,                  // APB write data
    output logic      [DATA_W-1:0]    prdata,                  // APB read data
    output logic                      pready,                  // APB ready
    output logic                      pslverr,                 // APB error
    input  wire logic                 data_set_ready_n_port1,  // Modem ready, port 1
    input  wire logic                 data_set_ready_n_port2,  // Modem ready, port 2
    input  wire logic                 clear_to_send_n_port1,   // Modem clear, port 1
    input  wire logic                 clear_to_send_n_port2,   // Modem clear, port 2
    output logic                      request_to_send_n_port1, // Request, port 1
    output logic                      request_to_send_n_port2, // Request, port 2
    output logic                      terminal_ready_n_port1,  // Terminal ready, port 1
    output logic                      terminal_ready_n_port2,  // Terminal ready, port 2
    output logic                      irq                      // Interrupt, active high
);
    import umh_pkg::*;

    // Byte address of a per-port register
    function automatic logic [ADDR_W-1:0] portAddr(input int port, input logic [7:0] off);
        portAddr = ADDR_W'(off + port * PORT_STRIDE);
    endfunction

    // Status byte of one port, unused bits read zero
    function automatic logic [DATA_W-1:0] msrWord(input logic dsrN, input logic ctsN,
                                                  input logic dDsr, input logic dCts);
        logic [DATA_W-1:0] w;
        w = DATA_ZERO;
        w[MSR_DSR]  = ~dsrN;
        w[MSR_CTS]  = ~ctsN;
        w[MSR_DDSR] = dDsr;
        w[MSR_DCTS] = dCts;
        msrWord = w;
    endfunction

    // Bus state
    logic                   pready_q;
    logic                   pready_d;
    logic [DATA_W-1:0]      prdata_q;
    logic [DATA_W-1:0]      prdata_d;
    logic                   pslverr_q;
    logic                   pslverr_d;

    // Interrupt block
    logic [INT_W-1:0]       intStat_q;
    logic [INT_W-1:0]       intStat_d;
    logic [INT_W-1:0]       intEn_q;
    logic [INT_W-1:0]       intEn_d;
    logic                   irq_q;
    logic                   irq_d;

    // Per-port state
    logic [NUM_PORTS-1:0]   dtrBit_q;
    logic [NUM_PORTS-1:0]   rtsBit_q;
    logic [NUM_PORTS-1:0]   loop_q;
    logic [NUM_PORTS-1:0]   msiEn_q;
    logic [NUM_PORTS-1:0]   deltaDsr_q;
    logic [NUM_PORTS-1:0]   deltaCts_q;
    logic [NUM_PORTS-1:0]   rtsN_q;
    logic [NUM_PORTS-1:0]   dtrN_q;

    // Next values of the per-port flops
    logic [NUM_PORTS-1:0]   deltaDsr_d;
    logic [NUM_PORTS-1:0]   deltaCts_d;
    logic [NUM_PORTS-1:0]   rtsN_d;
    logic [NUM_PORTS-1:0]   dtrN_d;

    // Per-port decode and read data
    logic [NUM_PORTS-1:0]   hitMsr;
    logic [NUM_PORTS-1:0]   hitMcr;
    logic [NUM_PORTS-1:0]   hitIer;
    logic [NUM_PORTS-1:0]   rdMsr;
    logic [NUM_PORTS-1:0]   wrMcr;
    logic [NUM_PORTS-1:0]   wrIer;
    logic [NUM_PORTS-1:0]   modemEvent;
    logic [DATA_W-1:0]      portRd [NUM_PORTS];
    logic [DATA_W-1:0]      msrRd  [NUM_PORTS];
    logic [DATA_W-1:0]      mcrRd  [NUM_PORTS];
    logic [DATA_W-1:0]      ierRd  [NUM_PORTS];

    // Global decode
    wire                    accessPhase;
    wire                    xferDone;
    wire                    wrDone;
    wire                    rdDone;
    wire                    hitIntStat;
    wire                    hitIntClr;
    wire                    hitIntEn;
    wire                    hitAnyPort;
    wire                    mapped;
    wire                    badAccess;
    wire [DATA_W-1:0]       portRdAny;
    wire [DATA_W-1:0]       intRd;
    wire [DATA_W-1:0]       readData;
    wire [INT_W-1:0]        intClrMask;
    wire                    wrIntClr;
    wire                    wrIntEn;
    umh_sel_t               readSel;

    umh_pin_if pinBus [NUM_PORTS] ();

    umh_pin_sync u_sync_port1 (
        .core_clk (core_clk),
        .reset    (reset),
        .dsrN     (data_set_ready_n_port1),
        .ctsN     (clear_to_send_n_port1),
        .pins     (pinBus[0])
    );

    umh_pin_sync u_sync_port2 (
        .core_clk (core_clk),
        .reset    (reset),
        .dsrN     (data_set_ready_n_port2),
        .ctsN     (clear_to_send_n_port2),
        .pins     (pinBus[1])
    );

    // One wait state: pready rises in the second access cycle
    assign accessPhase = psel & penable;
    assign xferDone    = accessPhase & pready_q;
    assign wrDone      = xferDone & pwrite;
    assign rdDone      = xferDone & ~pwrite;

    assign hitIntStat  = (paddr == OFF_INT_STATUS);
    assign hitIntClr   = (paddr == OFF_INT_CLEAR);
    assign hitIntEn    = (paddr == OFF_INT_ENABLE);
    assign hitAnyPort  = |{hitMsr, hitMcr, hitIer};
    assign mapped      = hitAnyPort | hitIntStat | hitIntClr | hitIntEn;

    // Status and clear are one-way; the wrong direction is an error
    assign badAccess   = ~mapped
                       | (hitIntStat & pwrite)
                       | (hitIntClr & ~pwrite)
                       | (|hitMsr & pwrite);

    assign wrIntClr    = wrDone & hitIntClr;
    assign wrIntEn     = wrDone & hitIntEn;
    assign intClrMask  = wrIntClr ? pwdata[INT_W-1:0] : INT_RST;

    assign readSel     = hitAnyPort ? UMH_SEL_PORT
                       : (hitIntStat | hitIntEn) ? UMH_SEL_INT
                       : UMH_SEL_NONE;

    assign portRdAny   = portRd[0] | portRd[1];
    assign intRd       = hitIntStat ? {{(DATA_W-INT_W){1'b0}}, intStat_q}
                                    : {{(DATA_W-INT_W){1'b0}}, intEn_q};

    assign readData    = (readSel == UMH_SEL_PORT) ? portRdAny
                       : (readSel == UMH_SEL_INT)  ? intRd
                       : DATA_ZERO;

    // Data is latched in the first access cycle and held while pready is high
    assign pready_d    = accessPhase & ~pready_q;
    assign prdata_d    = pready_d ? (pwrite ? DATA_ZERO : readData) : prdata_q;
    assign pslverr_d   = pready_d & badAccess;

    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_port
            assign hitMsr[p] = (paddr == portAddr(p, OFF_MSR));
            assign hitMcr[p] = (paddr == portAddr(p, OFF_MCR));
            assign hitIer[p] = (paddr == portAddr(p, OFF_IER));
            assign rdMsr[p]  = rdDone & hitMsr[p];
            assign wrMcr[p]  = wrDone & hitMcr[p];
            assign wrIer[p]  = wrDone & hitIer[p];

            // Any edge of either pin counts, not only the rising ones
            assign modemEvent[p] = msiEn_q[p]
                                 & (pinBus[p].dsrChange | pinBus[p].ctsChange);

            // Clear-to-send reaches only status and interrupt logic
            assign msrRd[p]  = msrWord(pinBus[p].dsrLevelN, pinBus[p].ctsLevelN,
                                       deltaDsr_q[p], deltaCts_q[p]);
            assign mcrRd[p]  = DATA_ZERO | (DATA_W'(dtrBit_q[p]) << MCR_DTR)
                                         | (DATA_W'(rtsBit_q[p]) << MCR_RTS)
                                         | (DATA_W'(loop_q[p]) << MCR_LOOP);
            assign ierRd[p]  = DATA_ZERO | (DATA_W'(msiEn_q[p]) << IER_MSI);
            assign portRd[p] = hitMsr[p] ? msrRd[p]
                             : hitMcr[p] ? mcrRd[p]
                             : hitIer[p] ? ierRd[p]
                             : DATA_ZERO;

            // Control bits land on the completing edge of a write
            always_ff @(posedge core_clk) begin
                if (reset) begin
                    dtrBit_q[p] <= BIT_RST;
                end else if (wrMcr[p]) begin
                    dtrBit_q[p] <= pwdata[MCR_DTR];
                end
            end

            always_ff @(posedge core_clk) begin
                if (reset) begin
                    rtsBit_q[p] <= BIT_RST;
                end else if (wrMcr[p]) begin
                    rtsBit_q[p] <= pwdata[MCR_RTS];
                end
            end

            always_ff @(posedge core_clk) begin
                if (reset) begin
                    loop_q[p] <= BIT_RST;
                end else if (wrMcr[p]) begin
                    loop_q[p] <= pwdata[MCR_LOOP];
                end
            end

            always_ff @(posedge core_clk) begin
                if (reset) begin
                    msiEn_q[p] <= BIT_RST;
                end else if (wrIer[p]) begin
                    msiEn_q[p] <= pwdata[IER_MSI];
                end
            end

            // A rise in the same cycle as the read survives the clear
            assign deltaDsr_d[p] = pinBus[p].dsrRise | (deltaDsr_q[p] & ~rdMsr[p]);
            assign deltaCts_d[p] = pinBus[p].ctsRise | (deltaCts_q[p] & ~rdMsr[p]);

            always_ff @(posedge core_clk) begin
                if (reset) begin
                    deltaDsr_q[p] <= BIT_RST;
                end else begin
                    deltaDsr_q[p] <= deltaDsr_d[p];
                end
            end

            always_ff @(posedge core_clk) begin
                if (reset) begin
                    deltaCts_q[p] <= BIT_RST;
                end else begin
                    deltaCts_q[p] <= deltaCts_d[p];
                end
            end

            // Pins follow the stored control bits one cycle after the write
            // Loop mode parks both outputs at their idle level
            assign rtsN_d[p] = ~(rtsBit_q[p] & ~loop_q[p]);
            assign dtrN_d[p] = ~(dtrBit_q[p] & ~loop_q[p]);

            always_ff @(posedge core_clk) begin
                if (reset) begin
                    rtsN_q[p] <= PIN_IDLE;
                end else begin
                    rtsN_q[p] <= rtsN_d[p];
                end
            end

            always_ff @(posedge core_clk) begin
                if (reset) begin
                    dtrN_q[p] <= PIN_IDLE;
                end else begin
                    dtrN_q[p] <= dtrN_d[p];
                end
            end
        end
    endgenerate

    // Sticky modem-status events; the event wins over any clear
    assign intStat_d = modemEvent | (intStat_q & ~rdMsr & ~intClrMask);
    assign intEn_d   = wrIntEn ? pwdata[INT_W-1:0] : intEn_q;
    assign irq_d     = |(intStat_d & intEn_d);

    always_ff @(posedge core_clk) begin
        if (reset) begin
            intStat_q <= INT_RST;
        end else begin
            intStat_q <= intStat_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            intEn_q <= INT_RST;
        end else begin
            intEn_q <= intEn_d;
        end
    end

    // Registered so the pin stays clean while status settles
    always_ff @(posedge core_clk) begin
        if (reset) begin
            irq_q <= BIT_RST;
        end else begin
            irq_q <= irq_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pready_q <= BIT_RST;
        end else begin
            pready_q <= pready_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            prdata_q <= DATA_ZERO;
        end else begin
            prdata_q <= prdata_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pslverr_q <= BIT_RST;
        end else begin
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata                  = prdata_q;
    assign pready                  = pready_q;
    assign pslverr                 = pslverr_q;
    assign irq                     = irq_q;
    assign request_to_send_n_port1 = rtsN_q[0];
    assign request_to_send_n_port2 = rtsN_q[1];
    assign terminal_ready_n_port1  = dtrN_q[0];
    assign terminal_ready_n_port2  = dtrN_q[1];

endmodule

/* File: bench/umh_modem_model.sv */
// Behavioural modem that answers request and terminal-ready after a delay
`timescale 1ns/1ps
module umh_modem_model (
    input  wire logic       core_clk, // Clock
    input  wire logic [3:0] lag,      // Reply delay in cycles
    input  wire logic [1:0] rtsN,     // Request, per port
    input  wire logic [1:0] dtrN,     // Terminal ready, per port
    output logic      [1:0] ctsN,     // Clear to send, per port
    output logic      [1:0] dsrN      // Data set ready, per port
);
    logic [15:0] rH [2];
    logic [15:0] dH [2];
    initial begin
        rH = '{2{16'hFFFF}};
        dH = '{2{16'hFFFF}};
    end
    always @(posedge core_clk) begin
        for (int p = 0; p < 2; p++) begin
            rH[p] <= {rH[p][14:0], rtsN[p]};
            dH[p] <= {dH[p][14:0], dtrN[p]};
        end
    end
    // Lines go low only once the host asks; lag sets prompt or slow replies
    for (genvar p = 0; p < 2; p++) begin : g_port
        assign ctsN[p] = rH[p][lag];
        assign dsrN[p] = dH[p][lag];
    end
endmodule

/* File: bench/umh_handshake_checker.sv */
// Port assertions of the modem handshake block
`timescale 1ns/1ps
module umh_handshake_checker (
    input wire logic                       core_clk,                // Clock
    input wire logic                       reset,                   // Reset
    input wire logic                       psel,                    // Select
    input wire logic                       penable,                 // Enable
    input wire logic                       pwrite,                  // Direction
    input wire logic [umh_pkg::ADDR_W-1:0] paddr,                   // Address
    input wire logic [umh_pkg::DATA_W-1:0] pwdata,                  // Write data
    input wire logic [umh_pkg::DATA_W-1:0] prdata,                  // Read data
    input wire logic                       pready,                  // Ready
    input wire logic                       pslverr,                 // Error
    input wire logic                       data_set_ready_n_port1,  // Ready in
    input wire logic                       clear_to_send_n_port1,   // Clear in
    input wire logic                       request_to_send_n_port1, // Request out
    input wire logic                       request_to_send_n_port2, // Request out
    input wire logic                       terminal_ready_n_port1,  // Ready out
    input wire logic                       terminal_ready_n_port2,  // Ready out
    input wire logic                       irq                      // Interrupt
);
    import umh_pkg::*;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (reset);
    wire done    = psel && penable && pready;
    wire wrMcr1  = done && pwrite && paddr == OFF_MCR;
    wire wrMcr2  = done && pwrite && paddr == PORT_STRIDE + OFF_MCR;
    wire rdMsr1  = done && !pwrite && paddr == OFF_MSR;
    wire rtsWant = !(pwdata[MCR_RTS] && !pwdata[MCR_LOOP]);
    wire dtrWant = !(pwdata[MCR_DTR] && !pwdata[MCR_LOOP]);
    logic       ierQ;
    logic       dsrQ;
    logic       ctsQ;
    logic [1:0] intEnQ;
    logic [2:0] dsrAgeQ;
    logic [2:0] ctsAgeQ;
    // Ages: a pin level is trusted only well past the synchroniser delay
    always_ff @(posedge core_clk) begin
        dsrQ    <= data_set_ready_n_port1;
        ctsQ    <= clear_to_send_n_port1;
        dsrAgeQ <= (reset || dsrQ != data_set_ready_n_port1) ? 3'h0
                 : dsrAgeQ + {2'h0, dsrAgeQ != 3'h7};
        ctsAgeQ <= (reset || ctsQ != clear_to_send_n_port1) ? 3'h0
                 : ctsAgeQ + {2'h0, ctsAgeQ != 3'h7};
        if (reset) begin
            ierQ   <= 1'b0;
            intEnQ <= 2'h0;
        end else if (done && pwrite && paddr == OFF_IER) begin
            ierQ <= pwdata[IER_MSI];
        end else if (done && pwrite && paddr == OFF_INT_ENABLE) begin
            intEnQ <= pwdata[1:0];
        end
    end
    a_idle_after_reset: assert property (
        $fell(reset) |-> request_to_send_n_port1 && request_to_send_n_port2
            && terminal_ready_n_port1 && terminal_ready_n_port2)
        else $error("outputs not idle after reset");
    a_rts_follows: assert property (
        wrMcr1 |-> ##3 request_to_send_n_port1 == $past(rtsWant, 3))
        else $error("request pin does not follow control");
    a_dtr_follows: assert property (
        wrMcr2 |-> ##3 terminal_ready_n_port2 == $past(dtrWant, 3))
        else $error("terminal ready pin does not follow control");
    a_loop_forces: assert property (
        wrMcr1 && pwdata[MCR_LOOP] |-> ##3 request_to_send_n_port1 && terminal_ready_n_port1)
        else $error("loop mode left an output active");
    a_status_readonly: assert property (
        done && pwrite && paddr == OFF_MSR |-> pslverr)
        else $error("status write not refused");
    a_dsr_level: assert property (
        rdMsr1 && dsrAgeQ == 3'h7 |-> prdata[MSR_DSR] == !data_set_ready_n_port1)
        else $error("status ready bit wrong");
    a_cts_level: assert property (
        rdMsr1 && ctsAgeQ == 3'h7 |-> prdata[MSR_CTS] == !clear_to_send_n_port1)
        else $error("status clear bit wrong");
    a_dsr_irq: assert property (
        $changed(data_set_ready_n_port1) && ierQ && intEnQ[0] |-> ##[1:8] irq)
        else $error("ready change gave no interrupt");
    a_cts_irq: assert property (
        $changed(clear_to_send_n_port1) && ierQ && intEnQ[0] |-> ##[1:8] irq)
        else $error("clear change gave no interrupt");
    a_read_clears: assert property (
        rdMsr1 && dsrAgeQ == 3'h7 && ctsAgeQ == 3'h7 && intEnQ == 2'h1 |-> ##2 !irq)
        else $error("status read left interrupt pending");
endmodule

/* File: bench/testbench.sv */
// Self-checking bench of the modem handshake block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin testsRun++; if ((g) !== (e)) begin errTotal++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module testbench;
    import umh_pkg::*;
    logic              core_clk = 1'b0;
    logic              reset    = 1'b1;
    logic              psel     = 1'b0;
    logic              penable  = 1'b0;
    logic              pwrite   = 1'b0;
    logic [ADDR_W-1:0] paddr    = 8'h00;
    logic [DATA_W-1:0] pwdata   = 32'h0000_0000;
    logic [3:0]        lag      = 4'h3;
    logic [1:0]        ctsOn    = 2'h0;
    logic [1:0]        dsrOn    = 2'h0;
    logic [1:0]        pend     = 2'h0;
    logic [1:0]        dlt [2];
    logic [32:0]       expQ [$];
    logic [32:0]       expV;
    wire  [DATA_W-1:0] prdata;
    wire               pready, pslverr, irq;
    wire  [1:0]        rtsN, dtrN, ctsN, dsrN;
    int                errTotal = 0;
    int                testsRun = 0;
    always #25 core_clk = ~core_clk;
    umh_handshake i_dut (
        .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq),
        .data_set_ready_n_port1(dsrN[0]), .data_set_ready_n_port2(dsrN[1]),
        .clear_to_send_n_port1(ctsN[0]), .clear_to_send_n_port2(ctsN[1]),
        .request_to_send_n_port1(rtsN[0]), .request_to_send_n_port2(rtsN[1]),
        .terminal_ready_n_port1(dtrN[0]), .terminal_ready_n_port2(dtrN[1]));
    umh_modem_model i_modem (
        .core_clk(core_clk), .lag(lag), .rtsN(rtsN), .dtrN(dtrN), .ctsN(ctsN),
        .dsrN(dsrN));
    task automatic stopTest();
        $display("checks %0d mismatches %0d", testsRun, errTotal);
        if (errTotal == 0 && testsRun > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // One transfer; the answer is judged by the monitor below
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        int n;
        n = 0;
        expQ.push_back(e);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            errTotal++;
            stopTest();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    always @(posedge core_clk) begin
        if (psel && penable && pready === 1'b1) begin
            expV = expQ.size() > 0 ? expQ.pop_front() : 33'h1_FFFF_FFFF;
            `CHK("apb answer", expV, {pslverr, prdata})
        end
    end
    // Program one port, let the modem reply, then check pins, status and interrupt
    task automatic step(input int p, input logic [31:0] v);
        logic [7:0]  base;
        logic [31:0] m;
        logic        rtsOn, dtrOn;
        base  = p ? PORT_STRIDE : OFF_MSR;
        rtsOn = v[MCR_RTS] && !v[MCR_LOOP];
        dtrOn = v[MCR_DTR] && !v[MCR_LOOP];
        if (ctsOn[p] && !rtsOn) dlt[p][MSR_DCTS] = 1'b1;
        if (dsrOn[p] && !dtrOn) dlt[p][MSR_DDSR] = 1'b1;
        if (ctsOn[p] != rtsOn || dsrOn[p] != dtrOn) pend[p] = 1'b1;
        ctsOn[p] = rtsOn;
        dsrOn[p] = dtrOn;
        apb(1'b1, base + OFF_MCR, v, {1'b0, DATA_ZERO});
        apb(1'b0, base + OFF_MCR, DATA_ZERO, {1'b0, v & 32'h0000_0013});
        repeat (24) @(posedge core_clk);
        `CHK("request pin", !rtsOn, rtsN[p])
        `CHK("ready pin", !dtrOn, dtrN[p])
        `CHK("irq", pend[0], irq)
        if (v[8]) begin
            apb(1'b1, OFF_INT_CLEAR, 32'h0000_0001, {1'b0, DATA_ZERO});
            pend[0] = 1'b0;
            repeat (2) @(posedge core_clk);
            `CHK("irq cleared", 1'b0, irq)
        end
        apb(1'b0, OFF_INT_STATUS, DATA_ZERO, {31'h0000_0000, pend});
        m = DATA_ZERO;
        m[MSR_DSR] = dsrOn[p];
        m[MSR_CTS] = ctsOn[p];
        m[1:0] = dlt[p];
        apb(1'b0, base, DATA_ZERO, {1'b0, m});
        dlt[p] = 2'h0;
        pend[p] = 1'b0;
        repeat (2) @(posedge core_clk);
        `CHK("irq after read", 1'b0, irq)
    endtask
    initial begin
        void'($urandom(32'h6699));
        dlt[0] = 2'h0;
        dlt[1] = 2'h0;
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        `CHK("idle pins", 5'h0F, {irq, rtsN, dtrN})
        $display("reset test done");
        apb(1'b1, OFF_MSR, 32'hFFFF_FFFF, {1'b1, DATA_ZERO});
        apb(1'b0, OFF_INT_CLEAR, DATA_ZERO, {1'b1, DATA_ZERO});
        apb(1'b0, 8'h40, DATA_ZERO, {1'b1, DATA_ZERO});
        apb(1'b0, OFF_MSR, DATA_ZERO, {1'b0, DATA_ZERO});
        apb(1'b1, OFF_IER, 32'hFFFF_FFFF, {1'b0, DATA_ZERO});
        apb(1'b0, OFF_IER, DATA_ZERO, 33'h0_0000_0008);
        apb(1'b1, PORT_STRIDE + OFF_IER, 32'h0000_0008, {1'b0, DATA_ZERO});
        apb(1'b0, PORT_STRIDE + OFF_IER, DATA_ZERO, 33'h0_0000_0008);
        apb(1'b1, OFF_INT_ENABLE, 32'h0000_0001, {1'b0, DATA_ZERO});
        $display("register test done");
        step(0, 32'h0000_0003);
        step(0, 32'h0000_0013);
        step(1, 32'h0000_0003);
        for (int i = 0; i < 20; i++) begin
            lag <= 4'($urandom_range(15, 1));
            step(i % 2, $urandom());
        end
        $display("random test done");
        stopTest();
    end
endmodule
bind umh_handshake umh_handshake_checker i_chk (
    .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq),
    .data_set_ready_n_port1(data_set_ready_n_port1),
    .clear_to_send_n_port1(clear_to_send_n_port1),
    .request_to_send_n_port1(request_to_send_n_port1),
    .request_to_send_n_port2(request_to_send_n_port2),
    .terminal_ready_n_port1(terminal_ready_n_port1),
    .terminal_ready_n_port2(terminal_ready_n_port2));
